//--- src/stc_pkg.sv
package stc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  STC_IDX_CFG      = 8'h02;
    localparam logic [7:0]  STC_IDX_STATUS   = 8'h03;
    localparam logic [7:0]  STC_IDX_CMD      = 8'h04;

    localparam logic [31:0] STC_CFG_RESET    = 32'h0000_0000;
    localparam logic [31:0] STC_CFG_WMASK    = 32'h0007_ffff;
    localparam logic [31:0] STC_STATUS_RESET = 32'h0000_0000;

    // field positions of start_trigger_config
    localparam int STC_HOLD_LSB    = 0;
    localparam int STC_SHADOW_BIT  = 4;
    localparam int STC_SRC_LSB     = 5;
    localparam int STC_POL_BIT     = 9;
    localparam int STC_IMMED_BIT   = 10;
    localparam int STC_BUSY_BIT    = 11;
    localparam int STC_QUEUE_LSB   = 12;
    localparam int STC_SHOPT_LSB   = 16;
    localparam int STC_CYCLIC_BIT  = 18;

    // status and command fields
    localparam int STC_ST_PEND_LSB  = 0;
    localparam int STC_ST_PIN_BIT   = 4;
    localparam int STC_ST_WAIT_BIT  = 5;
    localparam int STC_ST_CNT_LSB   = 8;
    localparam int STC_CMD_START_BIT = 0;

    localparam int STC_CNT_W = 8;

    typedef enum logic [1:0] {
        STC_SH_SINGLE    = 2'b00,
        STC_SH_DBL_SRAMP = 2'b01,
        STC_SH_DBL_NO_STOP_VELOCITY_T  = 2'b10,
        STC_SH_DBL_NO_VBEGIN_T = 2'b11
    } stc_shadow_e;

    // mirrors the bit layout of start_trigger_config
    typedef struct packed {
        logic [12:0] reserved;
        logic        cyclic_shadow;
        stc_shadow_e shadow_option;
        logic [3:0]  value_queue_select;
        logic        busy_state_en;
        logic        immediate_start;
        logic        start_polarity;
        logic [3:0]  trigger_source;
        logic        shadow_en;
        logic [3:0]  hold_select;
    } stc_cfg_s;

    // internal motion events, one-cycle pulses
    typedef struct packed {
        logic compare_match_event;
        logic velocity_reached;
        logic target_reached;
    } stc_evt_s;

endpackage

//--- src/stc_start_trigger_config.sv
// Operation
// (RL1) bits 3:0 make four parameters await start
// (RL2) bit 4 enables shadow register staging
// (RL3) zero trigger source disables all start generation
// (RL4) source bit 0 selects pin input, else output
// (RL5) source bits 1-3 select internal event triggers
// (RL6) polarity bit sets pin active level
// (RL7) immediate bit bypasses the start timer
// (RL8) busy state: weak active input, strong inactive output
// (RL9) zero queue field pipelines nothing
// (RL10) queue bits pick four values for pipelining
// (RL11) shadow option zero: single level, 13 parameters
// (RL12) options 1-3 select double-stage shadow variants
// (RL13) config register at index 0x02, resets zero
// (RL14) cyclic bit writes active parameters back to shadow
// (RL15) every start applies all staged values together
module stc_start_trigger_config (
    // apb
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // internal events and parameter writes
    input  wire stc_pkg::stc_evt_s    events,
    input  wire logic [3:0]           param_written,
    // start timer handshake
    output logic                      start_timer_launch,
    input  wire logic                 start_timer_done,
    // shared start pin
    input  wire logic                 start_pin_in,
    output logic                      start_pin_out,
    output logic                      start_pin_oe,
    output logic                      start_pin_weak,
    // controls toward the ramp generator
    output logic                      start_apply,
    output logic [3:0]                hold_select,
    output logic [3:0]                hold_release,
    output logic [3:0]                queue_transfer,
    output logic                      shadow_en,
    output stc_pkg::stc_shadow_e      shadow_option,
    output logic                      shadow_transfer,
    output logic                      shadow_writeback
);
    import stc_pkg::*;

    // level on the start pin for an active or inactive state
    function automatic logic pin_level(input logic active, input logic pol_hi);
        return active ? pol_hi : ~pol_hi;
    endfunction

    // waiting for the external start timer or not
    typedef enum logic {
        STC_TW_IDLE = 1'b0,
        STC_TW_WAIT = 1'b1
    } stc_twait_e;

    stc_cfg_s                 cfg_r;
    logic [31:0]              cfg_nxt;
    logic [3:0]               pend_r;
    logic [3:0]               pend_nxt;
    logic                     pin_act_prev_r;
    stc_twait_e               tmr_state_r;
    stc_twait_e               tmr_state_nxt;
    logic                     start_r;
    logic                     launch_r;
    logic [STC_CNT_W-1:0]     start_cnt_r;
    logic [31:0]              rdata_r;

    // apb decode
    wire       acc_phase = psel & penable;
    wire       wr_acc    = acc_phase & pwrite;
    wire       rd_acc    = acc_phase & ~pwrite;
    wire       word_ok   = (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);
    wire [7:0] idx       = paddr[9:2];
    wire       hit_cfg   = word_ok & (idx == STC_IDX_CFG);
    wire       hit_stat  = word_ok & (idx == STC_IDX_STATUS);
    wire       hit_cmd   = word_ok & (idx == STC_IDX_CMD);
    wire       hit_any   = hit_cfg | hit_stat | hit_cmd;

    // zero wait states keep the master's access phase to one cycle
    assign pready  = 1'b1;
    assign pslverr = acc_phase & ~hit_any;
    assign prdata  = rdata_r;

    // (RL13) config write path
    wire cfg_we = wr_acc & hit_cfg;
    assign cfg_nxt = pwdata & STC_CFG_WMASK;

    wire sw_start_req = wr_acc & hit_cmd & pwdata[STC_CMD_START_BIT];

    // field views
    wire [3:0] src       = cfg_r.trigger_source;
    // (RL3) timing set off
    wire       timing_en = (src != 4'h0);
    // (RL4) pin direction
    wire       pin_is_in = src[0];
    // (RL6) active level
    wire       pol_high  = cfg_r.start_polarity;
    wire       pin_act   = (start_pin_in == pin_level(1'b1, pol_high));

    // start sources
    // (RL5) internal event triggers
    wire evt_start = (src[1] & events.target_reached)
                   | (src[2] & events.velocity_reached)
                   | (src[3] & events.compare_match_event);

    // only an inactive-to-active change counts, so a held level fires once
    wire pin_edge  = timing_en & pin_is_in & pin_act & ~pin_act_prev_r;

    // (RL7) immediate or timed
    wire pin_now   = pin_edge & cfg_r.immediate_start;
    wire pin_timed = pin_edge & ~cfg_r.immediate_start;
    wire waiting    = (tmr_state_r == STC_TW_WAIT);
    wire tmr_enable = timing_en & ~cfg_r.immediate_start;
    wire timer_fire = waiting & start_timer_done;

    wire start_nxt = timing_en
                   & (evt_start | pin_now | timer_fire | sw_start_req);

    // timer wait sequencing
    // a new edge while waiting restarts the timer rather than queueing
    always_comb begin
        tmr_state_nxt = tmr_state_r;
        unique case (tmr_state_r)
            STC_TW_IDLE: begin
                if (tmr_enable && pin_timed) begin
                    tmr_state_nxt = STC_TW_WAIT;
                end
            end
            STC_TW_WAIT: begin
                if (!tmr_enable) begin
                    tmr_state_nxt = STC_TW_IDLE;
                end else if (pin_timed) begin
                    tmr_state_nxt = STC_TW_WAIT;
                end else if (timer_fire) begin
                    tmr_state_nxt = STC_TW_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_state_r <= STC_TW_IDLE;
        end else begin
            tmr_state_r <= tmr_state_nxt;
        end
    end

    // pending held changes
    // (RL1) mark held writes
    wire [3:0] hold_set = param_written & cfg_r.hold_select;

    // one flag per held parameter
    generate
        for (genvar g = 0; g < 4; g++) begin : g_pend
            // set wins over the release in the same cycle
            assign pend_nxt[g] = timing_en & (hold_set[g] | (pend_r[g] & ~start_r));

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend_r[g] <= 1'b0;
                end else begin
                    pend_r[g] <= pend_nxt[g];
                end
            end
        end
    endgenerate

    wire busy = (pend_r != 4'h0) | waiting;

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= stc_cfg_s'(STC_CFG_RESET);
        end else if (cfg_we) begin
            cfg_r <= stc_cfg_s'(cfg_nxt);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_act_prev_r <= 1'b0;
        end else begin
            pin_act_prev_r <= pin_act;
        end
    end

    // (RL15) single start pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 1'b0;
        end else begin
            start_r <= start_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            launch_r <= 1'b0;
        end else begin
            launch_r <= pin_timed;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_cnt_r <= '0;
        end else if (start_r) begin
            start_cnt_r <= start_cnt_r + STC_CNT_W'(1);
        end
    end

    // read data
    wire [31:0] status_word = STC_STATUS_RESET
        | (32'(pend_r)      << STC_ST_PEND_LSB)
        | (32'(pin_act)     << STC_ST_PIN_BIT)
        | (32'(waiting)     << STC_ST_WAIT_BIT)
        | (32'(start_cnt_r) << STC_ST_CNT_LSB);

    wire [31:0] rd_mux = hit_cfg  ? 32'(cfg_r) :
                         hit_stat ? status_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            rdata_r <= rd_mux;
        end
    end

    // start pin drive
    // (RL8) busy state drive
    wire out_mode   = timing_en & ~pin_is_in;
    wire in_weak    = timing_en & pin_is_in & cfg_r.busy_state_en & ~busy;
    wire out_strong = out_mode & (~cfg_r.busy_state_en | busy | start_r);

    // with busy state, an idle output releases the line so others can drive
    assign start_pin_oe   = out_strong | in_weak;
    assign start_pin_weak = in_weak;
    // (RL6) pin level
    assign start_pin_out  = pin_level(in_weak | start_r, pol_high);

    // outputs toward the ramp generator
    assign start_apply        = start_r;
    assign start_timer_launch = launch_r;
    assign hold_select        = cfg_r.hold_select;

    // (RL1) release on start
    assign hold_release = start_r ? pend_r : 4'h0;

    // (RL9) queue transfer gate
    // (RL10) per-value queue
    assign queue_transfer = start_r ? cfg_r.value_queue_select : 4'h0;

    // (RL2) shadow staging
    assign shadow_en = cfg_r.shadow_en;

    // (RL11) single level, (RL12) double-stage variants
    assign shadow_option = cfg_r.shadow_option;

    assign shadow_transfer = start_r & cfg_r.shadow_en;

    // (RL14) cyclic write back
    assign shadow_writeback = shadow_transfer & cfg_r.cyclic_shadow;

endmodule

//--- verification/stc_asserts.sv
module stc_asserts (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // start control
    input wire logic        start_timer_launch,
    input wire logic        start_pin_oe,
    input wire logic        start_pin_weak,
    input wire logic        start_apply,
    input wire logic [3:0]  hold_release,
    input wire logic [3:0]  queue_transfer,
    input wire logic        shadow_en,
    input wire logic        shadow_transfer,
    input wire logic        shadow_writeback
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read;
        psel && penable && !pwrite;
    endsequence
    a_apb_ready: assert property (s_setup ##1 penable |-> pready)
        else $error("access phase without pready");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_rd_stable: assert property (s_read |=> $stable(prdata))
        else $error("read data moved after access");
    a_gate_apply: assert property (!start_apply |-> !shadow_transfer
        && hold_release == 4'h0 && queue_transfer == 4'h0) else $error("strobe without start");
    a_shadow_xfer: assert property (start_apply |-> shadow_transfer == shadow_en)
        else $error("shadow transfer wrong");
    a_wb_needs_xfer: assert property (shadow_writeback |-> shadow_transfer)
        else $error("writeback without transfer");
    a_weak_oe: assert property (start_pin_weak |-> start_pin_oe)
        else $error("weak drive without enable");
    a_launch_pulse: assert property (start_timer_launch |=> !start_timer_launch)
        else $error("launch longer than one cycle");
endmodule

bind stc_start_trigger_config stc_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start_timer_launch(start_timer_launch),
    .start_pin_oe(start_pin_oe), .start_pin_weak(start_pin_weak),
    .start_apply(start_apply), .hold_release(hold_release),
    .queue_transfer(queue_transfer), .shadow_en(shadow_en),
    .shadow_transfer(shadow_transfer), .shadow_writeback(shadow_writeback));

//--- verification/stc_partner.sv
module stc_partner #(parameter int DELAY = 6) (
    // start timer
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic launch,
    output logic      done,
    // shared pin
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic pin_weak,
    input  wire logic ext_lvl,
    input  wire logic ext_oe,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic       last_r;
    assign pin = (pin_oe && !pin_weak) ? pin_out : ext_oe ? ext_lvl : pin_oe ? pin_out : ~last_r;
    assign done = (cnt_r == 8'h01);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
            last_r <= 1'b0;
        end else begin
            last_r <= pin;
            cnt_r <= launch ? 8'(DELAY) : (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
        end
    end
endmodule

//--- verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import stc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        ext_lvl = 1'b0;
    logic        ext_oe = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pw = 4'h0;
    stc_evt_s    ev = '0;
    logic [31:0] prdata, rq;
    logic        pready, pslverr, re, launch, done, pin, p_out, p_oe, p_weak, ap, st, wb, sh;
    logic [3:0]  hsel, hrel, qtr;
    stc_shadow_e opt;
    int          error_cnt, check_count, cyc, n_st, n_ln;
    stc_start_trigger_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(ev), .param_written(pw),
        .start_timer_launch(launch), .start_timer_done(done), .start_pin_in(pin),
        .start_pin_out(p_out), .start_pin_oe(p_oe), .start_pin_weak(p_weak),
        .start_apply(ap), .hold_select(hsel), .hold_release(hrel), .queue_transfer(qtr),
        .shadow_en(sh), .shadow_option(opt), .shadow_transfer(st), .shadow_writeback(wb));
    stc_partner #(.DELAY(5)) u_far (.pclk(pclk), .presetn(presetn), .launch(launch),
        .done(done), .pin_out(p_out), .pin_oe(p_oe), .pin_weak(p_weak), .ext_lvl(ext_lvl),
        .ext_oe(ext_oe), .pin(pin));
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (ap === 1'b1) n_st++;
        if (launch === 1'b1) n_ln++;
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] mk(input logic [3:0] h, s, q, input logic [1:0] o,
                                       input logic e, p, i, b, c);
        return {13'h0, c, o, q, b, i, p, s, e, h};
    endfunction
    task automatic fire(input logic [3:0] pend, q, input logic s, w);
        #1;
        while (ap !== 1'b1) @(posedge pclk) #1;
        chk("release", 32'(hrel), 32'(pend));
        chk("queue", 32'(qtr), 32'(q));
        chk("shadow", 32'(st), 32'(s));
        chk("writeback", 32'(wb), 32'(w));
        @(posedge pclk);
    endtask
    initial begin
        logic [31:0] r;
        logic [3:0]  h, q, p;
        r = $urandom(32'he1a995a8);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        chk("cfg_reset", rq, STC_CFG_RESET);
        r = $urandom();
        apb(1'b1, 12'h008, r);
        apb(1'b0, 12'h008, 32'h0);
        chk("cfg_rw", rq, r & STC_CFG_WMASK);
        apb(1'b1, 12'h0f0, r);
        chk("unmapped", 32'(re), 32'h1);
        for (int i = 0; i < 4; i++) begin
            h = 4'($urandom());
            p = 4'($urandom());
            q = (i == 0) ? 4'h0 : 4'($urandom());
            apb(1'b1, 12'h008, mk(h, 4'(2 << (i % 3)), q, 2'(i), i != 1, 1'b0, 1'b0, 1'b0,
                                  i[0]));
            chk("hold_sel", 32'(hsel), 32'(h));
            chk("sh_opt", 32'(opt), 32'(i));
            chk("sh_en", 32'(sh), 32'(i != 1));
            pw <= p;
            @(posedge pclk);
            pw <= 4'h0;
            ev <= 3'(1 << (i % 3));
            @(posedge pclk);
            ev <= '0;
            fire(p & h, q, i != 1, i == 3);
        end
        apb(1'b1, 12'h008, mk(4'h0, 4'h1, 4'h0, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
        ext_lvl <= 1'b1;
        fire(4'h0, 4'h0, 1'b0, 1'b0);
        apb(1'b1, 12'h008, mk(4'h0, 4'h1, 4'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        r = 32'(n_ln);
        ext_lvl <= 1'b0;
        fire(4'h0, 4'h0, 1'b0, 1'b0);
        chk("launch", 32'(n_ln), r + 32'h1);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h008, mk(4'h0, 4'h2, 4'h0, 2'h0, 1'b0, k[0], 1'b0, 1'b0, 1'b0));
            chk("pin_oe", 32'(p_oe), 32'h1);
            chk("pin_idle", 32'(p_out), 32'(!k[0]));
        end
        apb(1'b1, 12'h008, mk(4'h0, 4'h1, 4'h0, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
        chk("pin_weak", 32'({p_weak, p_out}), 32'h3);
        apb(1'b1, 12'h008, mk(4'hf, 4'h0, 4'hf, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        r = 32'(n_st);
        ev <= 3'h7;
        @(posedge pclk);
        ev <= '0;
        repeat (3) @(posedge pclk);
        chk("no_start", 32'(n_st), r);
        chk("released", 32'(p_oe), 32'h0);
        conclude();
    end
endmodule
